/* File: src/rsc_reset_ctrl.sv */
// reset source controller: combines causes, sequences reset, holds flags
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl #(
    parameter int POR_DELAY_CYC = rsc_pkg::POR_DELAY_CYC,
    parameter int LOSS_CYC      = rsc_pkg::LOSS_LIMIT_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire rsc_pkg::rsc_src_s src_in,
    input  wire rsc_pkg::rsc_sfr_s sfr_in,
    output logic [7:0]             sfr_rdata_out,
    output rsc_pkg::rsc_ctrl_s     ctrl_out
);
    if (POR_DELAY_CYC < 1 || POR_DELAY_CYC >= (1 << rsc_pkg::CNT_W)) begin : g_bad_por
        $error("power-on delay count does not fit the counter");
    end
    if (LOSS_CYC < 1 || LOSS_CYC >= (1 << rsc_pkg::CNT_W)) begin : g_bad_loss
        $error("clock loss timeout does not fit the counter");
    end

    rsc_pkg::rsc_regs_s q;
    rsc_pkg::rsc_regs_s d;

    logic                  por_done;
    logic                  loss_done;
    logic                  sup_live;
    logic                  probe_edge;
    rsc_pkg::rsc_source_e  req;

    // priority among simultaneous requests; supply and pin first, then clock loss ahead of the comparator
    function automatic rsc_pkg::rsc_source_e pick_source(
        input logic supply_fail,
        input logic pin_low,
        input logic loss_fire,
        input logic cmp_fire,
        input logic flash_fire,
        input logic wdt_fire,
        input logic sw_fire
    );
        rsc_pkg::rsc_source_e s;
        s = rsc_pkg::SRC_NONE;
        if (supply_fail) begin
            s = rsc_pkg::SRC_SUPPLY;
        end else if (pin_low) begin
            s = rsc_pkg::SRC_PIN;
        end else if (loss_fire) begin
            s = rsc_pkg::SRC_LOSS;
        end else if (cmp_fire) begin
            s = rsc_pkg::SRC_CMP;
        end else if (flash_fire) begin
            s = rsc_pkg::SRC_FLASH;
        end else if (wdt_fire) begin
            s = rsc_pkg::SRC_WDT;
        end else if (sw_fire) begin
            s = rsc_pkg::SRC_SW;
        end
        return s;
    endfunction : pick_source

    // flags seen after a reset from the given cause
    function automatic logic [7:0] cause_flags(input rsc_pkg::rsc_source_e c);
        logic [7:0] f;
        f = 8'h00;
        case (c)
            rsc_pkg::SRC_POR,
            rsc_pkg::SRC_SUPPLY: f[rsc_pkg::CB_POR]  = 1'b1;
            rsc_pkg::SRC_PIN:    f[rsc_pkg::CB_PIN]  = 1'b1;
            rsc_pkg::SRC_LOSS:   f[rsc_pkg::CB_LOSS] = 1'b1;
            rsc_pkg::SRC_CMP:    f[rsc_pkg::CB_CMP]  = 1'b1;
            rsc_pkg::SRC_FLASH:  f[rsc_pkg::CB_FERR] = 1'b1;
            rsc_pkg::SRC_WDT:    f[rsc_pkg::CB_WDT]  = 1'b1;
            rsc_pkg::SRC_SW:     f[rsc_pkg::CB_SW]   = 1'b1;
            default:             f = 8'h00;
        endcase
        return f;
    endfunction : cause_flags

    // power-on release delay runs only while the supply stays up
    rsc_counter #(
        .W (rsc_pkg::CNT_W)
    ) u_por_delay (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .clear_in (q.st != rsc_pkg::ST_POR_DELAY),
        .run_in   (q.st == rsc_pkg::ST_POR_DELAY),
        .limit_in (rsc_pkg::CNT_W'(POR_DELAY_CYC)),
        .done_out (por_done)
    );

    // clock loss watchdog: any probe edge restarts the count
    rsc_counter #(
        .W (rsc_pkg::CNT_W)
    ) u_clock_loss (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .clear_in (probe_edge || !q.loss_en || q.st != rsc_pkg::ST_RUN),
        .run_in   (1'b1),
        .limit_in (rsc_pkg::CNT_W'(LOSS_CYC)),
        .done_out (loss_done)
    );

    assign probe_edge = src_in.clock_probe != q.probe;
    assign sup_live   = q.lvl ? src_in.supply_above_high : src_in.supply_above_low;

    always_comb begin
        logic sup_fail;
        logic pin_low;
        logic flash_fire;
        logic sw_fire;
        logic in_reset;
        logic cause_wr;
        logic mon_wr;
        logic still;
        sup_fail   = 1'b0;
        still      = 1'b0;
        pin_low    = 1'b0;
        flash_fire = 1'b0;
        sw_fire    = 1'b0;
        in_reset   = 1'b0;
        cause_wr   = 1'b0;
        mon_wr     = 1'b0;
        req        = rsc_pkg::SRC_NONE;
        d          = q;
        d.probe    = src_in.clock_probe;
        d.rdata    = 8'h00;

        // monitor resets only when switched on and selected
        sup_fail   = q.mon_en && q.sup_src && !sup_live;
        // our own drive of the pin must not look like an external reset
        pin_low    = !src_in.reset_pin_n && !q.ctrl.pin_drive;
        flash_fire = src_in.flash_addr_error
                     || (src_in.flash_write_attempt && !q.mon_en);
        cause_wr   = sfr_in.wr && sfr_in.addr == rsc_pkg::ADDR_CAUSE;
        mon_wr     = sfr_in.wr && sfr_in.addr == rsc_pkg::ADDR_SUPPLY;
        sw_fire    = cause_wr && sfr_in.wdata[rsc_pkg::CB_SW];
        req        = pick_source(sup_fail, pin_low, q.loss_en && loss_done,
                                 q.cmp_en && src_in.cmp_below, flash_fire,
                                 src_in.wdt_timeout, sw_fire);

        case (q.st)
            rsc_pkg::ST_POWER_UP: begin
                // threshold is the low one until software says otherwise
                if (src_in.supply_above_low) begin
                    d.st = rsc_pkg::ST_POR_DELAY;
                end
            end
            rsc_pkg::ST_POR_DELAY: begin
                if (!src_in.supply_above_low) begin
                    d.st = rsc_pkg::ST_POWER_UP;
                end else if (por_done) begin
                    d.st    = rsc_pkg::ST_RUN;
                    d.flags = cause_flags(rsc_pkg::SRC_POR);
                end
            end
            rsc_pkg::ST_HOLD: begin
                if (q.hold != rsc_pkg::HOLD_MIN_CYC) begin
                    d.hold = q.hold + 3'h1;
                end
                case (q.cause)
                    rsc_pkg::SRC_SUPPLY: still = !sup_live;
                    rsc_pkg::SRC_PIN:    still = !src_in.reset_pin_n;
                    rsc_pkg::SRC_CMP:    still = src_in.cmp_below;
                    default:             still = 1'b0;
                endcase
                // pulse sources get a short fixed hold; no power-on delay here
                if (q.hold == rsc_pkg::HOLD_MIN_CYC && !still) begin
                    d.st    = rsc_pkg::ST_RUN;
                    d.flags = cause_flags(q.cause);
                end
            end
            rsc_pkg::ST_RUN: begin
                if (req != rsc_pkg::SRC_NONE) begin
                    d.st     = rsc_pkg::ST_HOLD;
                    d.cause  = req;
                    d.hold   = 3'h0;
                    // clock loss and comparator enables return to defaults; monitor state and selection are kept
                    d.loss_en = 1'b0;
                    d.cmp_en = 1'b0;
                end else begin
                    if (cause_wr) begin
                        d.sup_src = sfr_in.wdata[rsc_pkg::CB_POR];
                        d.loss_en = sfr_in.wdata[rsc_pkg::CB_LOSS];
                        d.cmp_en  = sfr_in.wdata[rsc_pkg::CB_CMP];
                    end
                    if (mon_wr) begin
                        d.mon_en = sfr_in.wdata[rsc_pkg::SB_EN];
                        d.lvl    = sfr_in.wdata[rsc_pkg::SB_LVL];
                    end
                    if (sfr_in.rd && sfr_in.addr == rsc_pkg::ADDR_CAUSE) begin
                        if (sfr_in.rmw) begin
                            // enable view, so a modify cannot copy flags back
                            d.rdata[rsc_pkg::CB_POR] = q.sup_src;
                            d.rdata[rsc_pkg::CB_LOSS] = q.loss_en;
                            d.rdata[rsc_pkg::CB_CMP] = q.cmp_en;
                        end else begin
                            d.rdata = q.flags;
                        end
                    end else if (sfr_in.rd && sfr_in.addr == rsc_pkg::ADDR_SUPPLY) begin
                        d.rdata[rsc_pkg::SB_EN]   = q.mon_en;
                        d.rdata[rsc_pkg::SB_STAT] = sup_live;
                        d.rdata[rsc_pkg::SB_LVL]  = q.lvl;
                    end
                end
            end
            default: begin
                d.st = rsc_pkg::ST_POWER_UP;
            end
        endcase

        in_reset = d.st != rsc_pkg::ST_RUN;

        // watchdog prescale restarts with every reset
        if (in_reset || q.div == rsc_pkg::WDT_CLK_DIV - 4'h1) begin
            d.div = 4'h0;
        end else begin
            d.div = q.div + 4'h1;
        end

        d.ctrl.sys_reset         = in_reset;
        d.ctrl.halt_cpu          = in_reset;
        d.ctrl.sfr_init          = in_reset;
        d.ctrl.irq_timer_disable = in_reset;
        // only the stack pointer is touched; data memory has no clear path
        d.ctrl.sp_reset          = in_reset;
        d.ctrl.port_load         = in_reset;
        d.ctrl.port_latch        = rsc_pkg::PORT_LATCH_RST;
        d.ctrl.port_open_drain   = in_reset;
        d.ctrl.weak_pullup_en    = 1'b1;
        d.ctrl.pin_drive         = in_reset
                                   && (d.st != rsc_pkg::ST_HOLD
                                       || d.cause == rsc_pkg::SRC_SUPPLY);
        d.ctrl.pc_load           = in_reset;
        d.ctrl.pc_value          = rsc_pkg::PC_RESET;
        d.ctrl.clk_internal      = in_reset;
        d.ctrl.wdt_force_en      = in_reset;
        d.ctrl.wdt_tick          = !in_reset && q.div == rsc_pkg::WDT_CLK_DIV - 4'h1;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            // power-on: monitor on and selected, low threshold
            q.st       <= rsc_pkg::ST_POWER_UP;
            q.cause    <= rsc_pkg::SRC_POR;
            q.flags    <= rsc_pkg::FLAGS_RESET;
            q.mon_en   <= 1'b1;
            q.lvl      <= 1'b0;
            q.sup_src  <= 1'b1;
            q.loss_en  <= 1'b0;
            q.cmp_en   <= 1'b0;
            q.probe    <= 1'b0;
            q.div      <= 4'h0;
            q.hold     <= 3'h0;
            q.rdata    <= 8'h00;
            q.ctrl     <= '{sys_reset: 1'b1, halt_cpu: 1'b1, sfr_init: 1'b1,
                            irq_timer_disable: 1'b1, sp_reset: 1'b1, port_load: 1'b1,
                            port_latch: rsc_pkg::PORT_LATCH_RST, port_open_drain: 1'b1,
                            weak_pullup_en: 1'b1, pin_drive: 1'b1, pc_load: 1'b1,
                            pc_value: rsc_pkg::PC_RESET, clk_internal: 1'b1,
                            wdt_force_en: 1'b1, wdt_tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata_out = q.rdata;
    assign ctrl_out      = q.ctrl;
endmodule : rsc_reset_ctrl
`default_nettype wire

/* File: src/rsc_pkg.sv */
// constants, types and carriers shared by the reset source controller
//
// Functional notes
// - reset halts core, initialises registers, quiets interrupts, timers
// - data memory kept; only stack pointer reinitialised
// - port latches all ones, open-drain, pullups kept on
// - power-on and supply resets drive reset pin low
// - on exit program counter zero, internal oscillator
// - watchdog enabled after reset, clocked at clock/12
// - power-up waits for threshold, then release delay
// - power-on and supply resets set its flag; other resets clear it
// - power-on enables monitor; others keep its state
// - selected monitor holds reset below threshold, no delay
// - flash write with monitor off forces flash reset
// - monitor enable bit seven, resets need selection
// - bit six reads live supply comparison
// - bit five selects threshold; low bits read zero
// - low reset pin holds reset; pin flag on exit
// - enabled clock loss over 100 us resets, flag
// - clock loss bit writes enable, reads cause flag
// - enabled comparator below resets, flag, pin undriven
// - illegal flash access resets, flash error flag set
// - watchdog timeout resets, sets flag, pin undriven
// - writing one to bit four forces reset
// - read-modify-write reads enables, not cause flags
package rsc_pkg;

    localparam logic [7:0] ADDR_CAUSE      = 8'hef;
    localparam logic [7:0] ADDR_SUPPLY     = 8'hff;

    // reset cause register bit positions
    localparam int         CB_PIN          = 0;
    localparam int         CB_POR          = 1;
    localparam int         CB_LOSS         = 2;
    localparam int         CB_WDT          = 3;
    localparam int         CB_SW           = 4;
    localparam int         CB_CMP          = 5;
    localparam int         CB_FERR         = 6;

    // supply monitor control bit positions
    localparam int         SB_EN           = 7;
    localparam int         SB_STAT         = 6;
    localparam int         SB_LVL          = 5;

    localparam logic [7:0] FLAGS_RESET     = 8'h02;
    localparam logic [7:0] PORT_LATCH_RST  = 8'hff;
    localparam logic [15:0] PC_RESET       = 16'h0000;

    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         POR_DELAY_NS    = 300000;
    localparam int         POR_DELAY_CYC   = POR_DELAY_NS / CLK_PERIOD_NS;
    localparam int         LOSS_LIMIT_NS   = 100000;
    localparam int         LOSS_LIMIT_CYC  = (LOSS_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WDT_CLK_DIV     = 4'hc;
    localparam logic [2:0] HOLD_MIN_CYC    = 3'h4;
    localparam int         CNT_W           = 16;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_POWER_UP,
        ST_POR_DELAY,
        ST_HOLD
    } rsc_state_e;

    typedef enum logic [3:0] {
        SRC_NONE,
        SRC_POR,
        SRC_SUPPLY,
        SRC_PIN,
        SRC_LOSS,
        SRC_CMP,
        SRC_FLASH,
        SRC_WDT,
        SRC_SW
    } rsc_source_e;

    typedef struct packed {
        logic        supply_above_low;
        logic        supply_above_high;
        logic        reset_pin_n;
        logic        clock_probe;
        logic        cmp_below;
        logic        wdt_timeout;
        logic        flash_addr_error;
        logic        flash_write_attempt;
    } rsc_src_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic        rmw;
        logic [7:0]  wdata;
    } rsc_sfr_s;

    typedef struct packed {
        logic        sys_reset;
        logic        halt_cpu;
        logic        sfr_init;
        logic        irq_timer_disable;
        logic        sp_reset;
        logic        port_load;
        logic [7:0]  port_latch;
        logic        port_open_drain;
        logic        weak_pullup_en;
        logic        pin_drive;
        logic        pc_load;
        logic [15:0] pc_value;
        logic        clk_internal;
        logic        wdt_force_en;
        logic        wdt_tick;
    } rsc_ctrl_s;

    typedef struct packed {
        rsc_state_e  st;
        rsc_source_e cause;
        logic [7:0]  flags;
        logic        mon_en;
        logic        lvl;
        logic        sup_src;
        logic        loss_en;
        logic        cmp_en;
        logic        probe;
        logic [3:0]  div;
        logic [2:0]  hold;
        logic [7:0]  rdata;
        rsc_ctrl_s   ctrl;
    } rsc_regs_s;

endpackage : rsc_pkg

/* File: src/rsc_counter.sv */
// saturating up counter that flags when it reaches its limit
`timescale 1ns/10ps
`default_nettype none
module rsc_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic         clear_in,
    input  wire logic         run_in,
    input  wire logic [W-1:0] limit_in,
    output logic              done_out
);
    if (W < 1) begin : g_bad_w
        $error("counter width must be at least one bit");
    end

    logic [W-1:0] count_q;

    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            count_q <= '0;
        end else if (run_in && count_q != limit_in) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign done_out = (count_q == limit_in);
endmodule : rsc_counter
`default_nettype wire

/* File: verification/rsc_reset_props.sv */
// concurrent checks on the reset source controller ports
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_props (
    input wire logic               clk_in,
    input wire logic               reset_in,
    input wire rsc_pkg::rsc_src_s  src_in,
    input wire rsc_pkg::rsc_sfr_s  sfr_in,
    input wire logic [7:0]         sfr_rdata_out,
    input wire rsc_pkg::rsc_ctrl_s ctrl_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    logic       run;
    logic [3:0] gap_q;
    logic       seen_q;

    assign run = !ctrl_out.sys_reset;

    // tick spacing is counted here, a repetition of eleven is too long to unroll
    always_ff @(posedge clk_in) begin
        if (reset_in || ctrl_out.sys_reset) begin
            gap_q  <= 4'h0;
            seen_q <= 1'b0;
        end else if (ctrl_out.wdt_tick) begin
            gap_q  <= 4'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 4'h1;
        end
    end

    sequence s_quiet_entry;
        ctrl_out.sys_reset && !ctrl_out.pin_drive;
    endsequence
    sequence s_rd_supply;
        run && sfr_in.rd && sfr_in.addr == rsc_pkg::ADDR_SUPPLY;
    endsequence

    a_wdt_quiet_entry: assert property (run && src_in.wdt_timeout |=> s_quiet_entry)
        else $error("watchdog timeout did not enter reset with pin released");
    a_pin_entry: assert property (run && !src_in.reset_pin_n |=> s_quiet_entry)
        else $error("low reset pin did not enter reset");
    a_flash_entry: assert property (run && src_in.flash_addr_error |=> s_quiet_entry)
        else $error("flash access error did not enter reset");
    a_soft_force: assert property (run && sfr_in.wr && sfr_in.addr == rsc_pkg::ADDR_CAUSE
        && sfr_in.wdata[rsc_pkg::CB_SW] |=> s_quiet_entry)
        else $error("software force did not enter reset");
    a_hold_min: assert property ($rose(ctrl_out.sys_reset) |-> ctrl_out.sys_reset[*5])
        else $error("reset held shorter than five cycles");
    a_reset_outputs: assert property (ctrl_out.sys_reset |-> ctrl_out.halt_cpu
        && ctrl_out.sfr_init && ctrl_out.irq_timer_disable && ctrl_out.sp_reset
        && ctrl_out.port_load && ctrl_out.port_open_drain && ctrl_out.pc_load
        && ctrl_out.pc_value == rsc_pkg::PC_RESET && ctrl_out.clk_internal
        && ctrl_out.wdt_force_en)
        else $error("a control output is wrong during reset");
    a_port_pullup: assert property (ctrl_out.weak_pullup_en
        && ctrl_out.port_latch == rsc_pkg::PORT_LATCH_RST)
        else $error("port load value or pullup wrong");
    a_drive_in_reset: assert property (ctrl_out.pin_drive |-> ctrl_out.sys_reset)
        else $error("reset pin driven outside reset");
    a_supply_hold: assert property (ctrl_out.pin_drive && !src_in.supply_above_low
        |=> ctrl_out.sys_reset && ctrl_out.pin_drive)
        else $error("reset released while supply low");
    a_tick_spacing: assert property (seen_q && run
        |-> (ctrl_out.wdt_tick ? gap_q == 4'hb : gap_q < 4'hb))
        else $error("watchdog tick not every twelve cycles");
    a_supply_read: assert property (s_rd_supply |=> sfr_rdata_out[4:0] == 5'h00
        && sfr_rdata_out[6] == (sfr_rdata_out[5] ? $past(src_in.supply_above_high)
        : $past(src_in.supply_above_low)))
        else $error("supply control read value wrong");
    a_rdata_idle: assert property (!sfr_in.rd || ctrl_out.sys_reset
        |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
endmodule : rsc_reset_props

bind rsc_reset_ctrl rsc_reset_props u_props (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .src_in        (src_in),
    .sfr_in        (sfr_in),
    .sfr_rdata_out (sfr_rdata_out),
    .ctrl_out      (ctrl_out)
);
`default_nettype wire

/* File: verification/rsc_supply_model.sv */
// supply rail, pulled-up reset pin and clock probe around the controller
`timescale 1ns/10ps
`default_nettype none
module rsc_supply_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] supply_lvl_in,
    input  wire logic       ext_low_in,
    input  wire logic       clock_run_in,
    input  wire logic       pin_drive_in,
    output logic            above_low_out,
    output logic            above_high_out,
    output logic            pin_n_out,
    output logic            probe_out
);
    logic tog_q = 1'b0;

    // level 0 is below both thresholds, 1 between them, 2 above both
    assign above_low_out  = supply_lvl_in != 2'h0;
    assign above_high_out = supply_lvl_in == 2'h2;
    // pulled up, so low only while some party pulls it down
    assign pin_n_out      = !(ext_low_in || pin_drive_in);
    assign probe_out      = tog_q;

    // a stopped probe holds its level, which is what a dead clock looks like
    always @(posedge clk_in) begin
        if (clock_run_in) begin
            tog_q <= !tog_q;
        end
    end
endmodule : rsc_supply_model
`default_nettype wire

/* File: verification/rsc_reset_ctrl_bench.sv */
// self-checking bench for the reset source controller
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl_bench;
    localparam int         POR_D  = 20;
    localparam int         LOSS_D = 16;
    localparam logic [7:0] CA     = rsc_pkg::ADDR_CAUSE;
    localparam logic [7:0] SA     = rsc_pkg::ADDR_SUPPLY;

    logic               clk_in       = 1'b0;
    logic               reset_in     = 1'b1;
    rsc_pkg::rsc_sfr_s  sfr_in       = '0;
    logic [1:0]         supply_lvl   = 2'h0;
    logic               ext_low      = 1'b0;
    logic               clock_run    = 1'b1;
    logic               cmp_below    = 1'b0;
    logic               wdt_to       = 1'b0;
    logic               ferr         = 1'b0;
    logic               fwr          = 1'b0;
    logic               lo, hi, pin_n, probe;
    rsc_pkg::rsc_src_s  src_in;
    rsc_pkg::rsc_ctrl_s ctrl;
    logic [7:0]         rdata;
    logic [7:0]         got;
    int                 n;
    int                 mismatches   = 0;
    int                 total_checks = 0;

    always #25 clk_in = !clk_in;

    assign src_in = {lo, hi, pin_n, probe, cmp_below, wdt_to, ferr, fwr};

    rsc_reset_ctrl #(.POR_DELAY_CYC(POR_D), .LOSS_CYC(LOSS_D)) uut (
        .clk_in(clk_in), .reset_in(reset_in), .src_in(src_in), .sfr_in(sfr_in),
        .sfr_rdata_out(rdata), .ctrl_out(ctrl));

    rsc_supply_model u_far (
        .clk_in(clk_in), .supply_lvl_in(supply_lvl), .ext_low_in(ext_low),
        .clock_run_in(clock_run), .pin_drive_in(ctrl.pin_drive), .above_low_out(lo),
        .above_high_out(hi), .pin_n_out(pin_n), .probe_out(probe));

    task automatic tally_and_finish;
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check8(input logic [7:0] exp, input logic [7:0] act);
        total_checks++;
        if (act !== exp) begin
            mismatches++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, act);
        end
    endtask : check8

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_in = '{a, 1'b1, 1'b0, 1'b0, d};
        @(negedge clk_in);
        sfr_in.wr = 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, input logic m, output logic [7:0] d);
        @(negedge clk_in);
        sfr_in = '{a, 1'b0, 1'b1, m, 8'h00};
        @(negedge clk_in);
        sfr_in.rd = 1'b0;
        d = rdata;
    endtask : sfr_rd

    task automatic pulse(input logic [2:0] sel);
        @(negedge clk_in);
        {wdt_to, ferr, fwr} = sel;
        @(negedge clk_in);
        {wdt_to, ferr, fwr} = 3'h0;
    endtask : pulse

    // counts falling edges until sys_reset shows the wanted level
    task automatic wait_rst(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while (ctrl.sys_reset !== lvl) begin
            @(negedge clk_in);
            cnt++;
            if (cnt > bound) begin
                mismatches++;
                tally_and_finish();
            end
        end
    endtask : wait_rst

    task automatic expect_cause(input int bound, input logic drv, input logic [7:0] flags);
        wait_rst(1'b1, bound, n);
        check8({7'h0, drv}, {7'h0, ctrl.pin_drive});
        wait_rst(1'b0, 60, n);
        sfr_rd(CA, 1'b0, got);
        check8(flags, got);
    endtask : expect_cause

    task automatic sc_power_up;
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (5) @(negedge clk_in);
        check8({6'h0, ctrl.sys_reset, ctrl.pin_drive}, 8'h03);
        supply_lvl = 2'h2;
        wait_rst(1'b0, POR_D + 10, n);
        check8(8'h01, 8'(n >= POR_D + 1 && n <= POR_D + 3));
        sfr_rd(CA, 1'b0, got);
        check8(8'h02, got);
        sfr_rd(CA, 1'b1, got);
        check8(8'h02, got);
        sfr_rd(SA, 1'b0, got);
        check8(8'hc0, got);
        sfr_wr(SA, 8'hbf);
        sfr_rd(SA, 1'b0, got);
        check8(8'he0, got);
    endtask : sc_power_up

    task automatic sc_supply_fail;
        @(negedge clk_in);
        supply_lvl = 2'h1;
        wait_rst(1'b1, 4, n);
        check8({7'h0, ctrl.pin_drive}, 8'h01);
        repeat (8) @(negedge clk_in);
        supply_lvl = 2'h2;
        wait_rst(1'b0, 20, n);
        check8(8'h01, 8'(n < POR_D));
        sfr_rd(CA, 1'b0, got);
        check8(8'h02, got);
    endtask : sc_supply_fail

    task automatic sc_watchdog;
        pulse(3'h4);
        expect_cause(4, 1'b0, 8'h08);
        check8(8'h05, 8'(n));
    endtask : sc_watchdog

    task automatic sc_software;
        sfr_wr(CA, 8'h02);
        check8({7'h0, ctrl.sys_reset}, 8'h00);
        sfr_wr(CA, 8'h12);
        expect_cause(4, 1'b0, 8'h10);
    endtask : sc_software

    task automatic sc_clock_loss;
        sfr_wr(CA, 8'h26);
        sfr_rd(CA, 1'b1, got);
        check8(8'h26, got);
        sfr_rd(CA, 1'b0, got);
        check8(8'h10, got);
        clock_run = 1'b0;
        expect_cause(LOSS_D + 8, 1'b0, 8'h04);
        clock_run = 1'b1;
    endtask : sc_clock_loss

    task automatic sc_comparator;
        cmp_below = 1'b1;
        repeat (4) @(negedge clk_in);
        check8({7'h0, ctrl.sys_reset}, 8'h00);
        sfr_wr(CA, 8'h22);
        wait_rst(1'b1, 6, n);
        cmp_below = 1'b0;
        expect_cause(4, 1'b0, 8'h20);
    endtask : sc_comparator

    task automatic sc_flash;
        pulse(3'h2);
        expect_cause(4, 1'b0, 8'h40);
        pulse(3'h1);
        @(negedge clk_in);
        check8({7'h0, ctrl.sys_reset}, 8'h00);
        sfr_wr(SA, 8'h00);
        pulse(3'h1);
        expect_cause(4, 1'b0, 8'h40);
        sfr_rd(SA, 1'b0, got);
        check8(8'h00, got & 8'h80);
        // monitor back on, settled about 5 us, then selected again
        sfr_wr(SA, 8'ha0);
        repeat (100) @(negedge clk_in);
        sfr_wr(CA, 8'h02);
    endtask : sc_flash

    task automatic sc_pin;
        @(negedge clk_in);
        ext_low = 1'b1;
        wait_rst(1'b1, 4, n);
        repeat (6) @(negedge clk_in);
        ext_low = 1'b0;
        expect_cause(4, 1'b0, 8'h01);
    endtask : sc_pin

    initial begin
        sc_power_up();
        sc_supply_fail();
        sc_watchdog();
        sc_software();
        sc_clock_loss();
        sc_comparator();
        sc_flash();
        sc_pin();
        tally_and_finish();
    end
endmodule : rsc_reset_ctrl_bench
`default_nettype wire
